// ===== cpu_interval_timer.sv
// 32-bit down-counting interval timer with prescaler, reload and interrupt
// assumes the register port master never waits; oscillator levels synchronous to clk
`include "cpu_interval_timer_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module cpu_interval_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  // tick sources
  input  wire logic        internal_oscillator_one,
  input  wire logic        internal_oscillator_two,
  input  wire logic        crystal_clock_source,
  // events
  output logic             timer_irq_pulse,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // reset release
  // asserts at once, lets go two edges after rst_n rises

  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state

  cpu_interval_timer_pkg::reg_req_t req;
  cpu_interval_timer_pkg::clk_src_t src_q;

  logic [31:0] timer_count_value_q;
  logic [31:0] timer_period_value_q;
  logic [15:0] timer_prescale_period_q;
  logic [15:0] timer_prescale_count_q;
  logic        overflow_q;
  logic        stop_q;
  logic        irq_status_q;
  logic        irq_mask_q;
  logic        irq_pulse_q;
  logic [31:0] rdata_q;
  logic        tick;
  logic        dec_tick;
  logic        reload;
  logic        at_zero;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  function automatic logic hit_wr(input cpu_interval_timer_pkg::reg_req_t r,
                                  input logic [7:0] ofs);
    hit_wr = r.wr && (r.addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // tick source and prescaler

  tick_select u_tick_select (
    .clk       (clk),
    .rst_n     (rst_sync_n),
    .sel       (src_q),
    .src_level ({crystal_clock_source, internal_oscillator_two,
                 internal_oscillator_one, 1'b1}),
    .tick      (tick)
  );

  // timer_reload_control write bit
  assign reload = hit_wr(req, `TMR_OFS_CONTROL) && req.wdata[`TMR_CTL_RELOAD_BIT];

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      timer_prescale_count_q <= `TMR_PRESCALE_RST;
    end else if (reload) begin
      timer_prescale_count_q <= timer_prescale_period_q;
    end else if (tick && !stop_q) begin
      if (timer_prescale_count_q == 16'h0000) begin
        timer_prescale_count_q <= timer_prescale_period_q;
      end else begin
        timer_prescale_count_q <= timer_prescale_count_q - 16'h0001;
      end
    end
  end

  // main counter steps once per prescale+1 ticks
  assign dec_tick = tick && !stop_q && (timer_prescale_count_q == 16'h0000);
  assign at_zero  = dec_tick && (timer_count_value_q == 32'h0000_0000);

  ////////////////////////////////////////////////////////////////////////////////
  // main counter

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      timer_count_value_q <= `TMR_PERIOD_RST;
    end else if (reload) begin
      timer_count_value_q <= timer_period_value_q;
    end else if (at_zero) begin
      timer_count_value_q <= timer_period_value_q;
    end else if (dec_tick) begin
      timer_count_value_q <= timer_count_value_q - 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt pulse

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_pulse_q <= 1'b0;
    end else begin
      irq_pulse_q <= at_zero;
    end
  end

  assign timer_irq_pulse = irq_pulse_q;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      timer_period_value_q    <= `TMR_PERIOD_RST;
      timer_prescale_period_q <= `TMR_PRESCALE_RST;
      src_q                   <= cpu_interval_timer_pkg::clk_src_t'(`TMR_CLKSRC_RST);
      stop_q                  <= 1'b0;
      irq_mask_q              <= 1'b0;
    end else begin
      if (hit_wr(req, `TMR_OFS_PERIOD)) begin
        timer_period_value_q <= req.wdata;
      end
      if (hit_wr(req, `TMR_OFS_PRESCALE)) begin
        timer_prescale_period_q <= req.wdata[15:0];
      end
      if (hit_wr(req, `TMR_OFS_CONTROL)) begin
        src_q  <= cpu_interval_timer_pkg::clk_src_t'(
                    req.wdata[`TMR_CTL_SRC_MSB:`TMR_CTL_SRC_LSB]);
        stop_q <= req.wdata[`TMR_CTL_STOP_BIT];
      end
      if (hit_wr(req, `TMR_OFS_IRQ_MASK)) begin
        irq_mask_q <= req.wdata[`TMR_IRQ_ZERO_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky flags: set wins over write-one-to-clear

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      overflow_q <= 1'b0;
    end else if (at_zero) begin
      overflow_q <= 1'b1;
    end else if (hit_wr(req, `TMR_OFS_CONTROL) && req.wdata[`TMR_CTL_OVF_BIT]) begin
      overflow_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_status_q <= 1'b0;
    end else if (at_zero) begin
      irq_status_q <= 1'b1;
    end else if (hit_wr(req, `TMR_OFS_IRQ_STATUS) && req.wdata[`TMR_IRQ_ZERO_BIT]) begin
      irq_status_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt line

  assign irq = irq_status_q & irq_mask_q;

  ////////////////////////////////////////////////////////////////////////////////
  // read port
  // read data stand for one cycle after rd, zero otherwise

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (req.rd) begin
      unique case (req.addr)
        `TMR_OFS_COUNT:      rdata_q <= timer_count_value_q;
        `TMR_OFS_PERIOD:     rdata_q <= timer_period_value_q;
        `TMR_OFS_PRESCALE:   rdata_q <= {timer_prescale_count_q, timer_prescale_period_q};
        `TMR_OFS_CONTROL:    rdata_q <= {23'h0, stop_q, 2'h0, src_q,
                                         2'h0, 1'b0, overflow_q};
        `TMR_OFS_IRQ_STATUS: rdata_q <= {31'h0, irq_status_q};
        `TMR_OFS_IRQ_MASK:   rdata_q <= {31'h0, irq_mask_q};
        default:             rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign rdata = rdata_q;

endmodule

`default_nettype wire

// ===== cpu_interval_timer_cfg.svh
// register offsets, field positions, reset values for the interval timer
// assumes a byte-addressed register port with 8-bit address, registers 4 apart
`ifndef CPU_INTERVAL_TIMER_CFG_SVH
`define CPU_INTERVAL_TIMER_CFG_SVH

`define TMR_ADDR_W            8
`define TMR_OFS_COUNT         8'h00
`define TMR_OFS_PERIOD        8'h04
`define TMR_OFS_PRESCALE      8'h08
`define TMR_OFS_CONTROL       8'h0C
`define TMR_OFS_IRQ_STATUS    8'h10
`define TMR_OFS_IRQ_MASK      8'h14

// control register fields
`define TMR_CTL_OVF_BIT       0
`define TMR_CTL_RELOAD_BIT    1
`define TMR_CTL_SRC_LSB       4
`define TMR_CTL_SRC_MSB       5
`define TMR_CTL_STOP_BIT      8

// interrupt status fields
`define TMR_IRQ_ZERO_BIT      0

`define TMR_PERIOD_RST        32'hFFFF_FFFF
`define TMR_PRESCALE_RST      16'h0000
`define TMR_CLKSRC_RST        2'h0

`endif

// ===== cpu_interval_timer_checker.sv
// port checker for the interval timer
// assumes the bind below onto cpu_interval_timer
`timescale 1ns/100ps
`default_nettype none
module cpu_interval_timer_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // register port and events
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        timer_irq_pulse,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] period_q;
  logic [2:0]  ctl_q;
  logic        pre_zero_q;
  logic        fast_q;
  logic        mask_q;
  ////////////////////////////////////////////////////////////
  // shadow of software-written settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_q <= 32'hFFFF_FFFF;
      ctl_q <= 3'h0;
      pre_zero_q <= 1'b1;
      fast_q <= 1'b1;
      mask_q <= 1'b0;
    end else if (wr) begin
      case (addr)
        8'h04: period_q <= wdata;
        8'h08: begin
          pre_zero_q <= (wdata[15:0] == 16'h0);
          fast_q <= 1'b0;
        end
        8'h0C: begin
          ctl_q <= {wdata[8], wdata[5:4]};
          if (wdata[1]) fast_q <= pre_zero_q;
        end
        8'h14: mask_q <= wdata[0];
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////
  read_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("rdata set without a read");
  period_read_a: assert property (rd && addr == 8'h04 |=> rdata == period_q)
    else $error("period read differs");
  ctl_read_a: assert property (
    rd && addr == 8'h0C |=> rdata[1] == 1'b0 && {rdata[8], rdata[5:4]} == ctl_q)
    else $error("control read differs");
  count_step_a: assert property (
    rd && addr == 8'h00 && fast_q && ctl_q == 3'h0 ##1 rd && addr == 8'h00
    |=> rdata == $past(rdata) - 32'h1 || $past(rdata) == 32'h0)
    else $error("count did not step by one");
  reload_load_a: assert property (
    wr && addr == 8'h0C && wdata[1] ##1 rd && addr == 8'h00 |=> rdata == period_q)
    else $error("reload did not load period");
  irq_cause_a: assert property (
    $rose(irq) |-> ($past(wr) or ##[0:1] timer_irq_pulse))
    else $error("irq rose without cause");
  irq_pulse_a: assert property (
    timer_irq_pulse && mask_q && !$past(wr) |-> irq)
    else $error("pulse without irq");
  irq_masked_a: assert property (!mask_q |-> !irq)
    else $error("irq while masked");
endmodule
bind cpu_interval_timer cpu_interval_timer_checker cpu_interval_timer_checker_i (.clk, .rst_n,
  .addr, .wdata, .wr, .rd, .rdata, .timer_irq_pulse, .irq);
`default_nettype wire

// ===== cpu_interval_timer_pkg.sv
// types shared by the interval timer files
// assumes cpu_interval_timer_cfg.svh is compiled alongside
package cpu_interval_timer_pkg;

  typedef enum logic [1:0] {
    src_system_clock_source     = 2'b00,
    src_internal_oscillator_one = 2'b01,
    src_internal_oscillator_two = 2'b10,
    src_crystal_clock_source    = 2'b11
  } clk_src_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

// ===== tb_cpu_interval_timer.sv
// self-checking bench for the interval timer
// assumes design and checker files compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_interval_timer;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [2:0]  osc_q = 3'h0;
  logic [31:0] rdata;
  logic        timer_irq_pulse;
  logic        irq;
  int          error_cnt = 0;
  int          compares = 0;
  int          n;
  always #2 clk = ~clk;
  always @(posedge clk) osc_q <= osc_q + 3'h1;
  cpu_interval_timer cpu_interval_timer_i (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .internal_oscillator_one(osc_q[0]), .internal_oscillator_two(osc_q[1]),
    .crystal_clock_source(osc_q[2]), .timer_irq_pulse, .irq);
  ////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // drives at a rising edge; the write is taken at the next edge
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    rd <= 1'b0;
    addr <= a;
    wdata <= d;
  endtask
  // one-cycle read strobe; data checked mid-cycle after the taking edge
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    wr <= 1'b0;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", exp, rdata);
  endtask
  // two reads of one address on consecutive edges
  task automatic rd_two(input logic [7:0] a, input logic [31:0] e0, input logic [31:0] e1);
    @(posedge clk);
    rd <= 1'b1;
    wr <= 1'b0;
    addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk("rdata", e0, rdata);
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", e1, rdata);
  endtask
  // lets a pending write be taken, then looks at settled outputs
  task automatic settle;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_pulse;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (timer_irq_pulse !== 1'b1 && n < 100);
    if (timer_irq_pulse !== 1'b1) begin
      error_cnt++;
      $display("mismatch timer_irq_pulse expected 1 seen 0");
      finish_test();
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(8'h04, 32'hFFFF_FFFF);
    rdc(8'h08, 32'h0);
    rdc(8'h0C, 32'h0);
    rdc(8'h14, 32'h0);
    rdc(8'h20, 32'h0);
    $display("test reset done");
    wrt(8'h04, 32'h64);
    wrt(8'h08, 32'h3);
    wrt(8'h0C, 32'h2);
    // prescale 3: one step per 4 cycles, reads land every 2 cycles
    for (int i = 0; i < 5; i++) begin
      rdc(8'h00, 32'h64 - 32'(i / 2));
    end
    wrt(8'h08, 32'h0);
    wrt(8'h0C, 32'h2);
    rd_two(8'h00, 32'h64, 32'h63);
    $display("test count done");
    wrt(8'h04, 32'h4);
    wrt(8'h14, 32'h1);
    for (int s = 0; s < 4; s++) begin
      wrt(8'h0C, {26'h0, s[1:0], 4'h2});
      wait_pulse();
      wait_pulse();
      chk("pulse_gap", 32'h5 << s, 32'(n));
    end
    chk("irq", 32'h1, {31'h0, irq});
    rdc(8'h10, 32'h1);
    wrt(8'h0C, 32'h130);
    rdc(8'h0C, 32'h131);
    wrt(8'h0C, 32'h131);
    rdc(8'h0C, 32'h130);
    wrt(8'h14, 32'h0);
    settle();
    chk("irq", 32'h0, {31'h0, irq});
    wrt(8'h14, 32'h1);
    settle();
    chk("irq", 32'h1, {31'h0, irq});
    wrt(8'h10, 32'h1);
    settle();
    chk("irq", 32'h0, {31'h0, irq});
    rdc(8'h10, 32'h0);
    $display("test irq done");
    finish_test();
  end
endmodule
`default_nettype wire

// ===== tick_select.sv
// tick source selector: picks one of four tick inputs; one-cycle pulse per rising edge, held high for the system clock source
// assumes tick inputs are synchronous levels or strobes on clk
`timescale 1ns/100ps
`default_nettype none

module tick_select (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  // selection
  input  wire cpu_interval_timer_pkg::clk_src_t sel,
  input  wire logic [3:0]                      src_level,
  // tick out
  output logic                                 tick
);

  logic prev_q;
  logic cur;

  always_comb begin
    unique case (sel)
      cpu_interval_timer_pkg::src_system_clock_source:     cur = src_level[0];
      cpu_interval_timer_pkg::src_internal_oscillator_one: cur = src_level[1];
      cpu_interval_timer_pkg::src_internal_oscillator_two: cur = src_level[2];
      cpu_interval_timer_pkg::src_crystal_clock_source:    cur = src_level[3];
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= cur;
    end
  end

  // system clock source ticks every cycle; others tick on rising edge
  assign tick = (sel == cpu_interval_timer_pkg::src_system_clock_source) ? 1'b1
              : (cur & ~prev_q);

endmodule

`default_nettype wire
